// ---- rtl/fepc_pkg.sv ----
// constants shared by the flash/eeprom program controller
package fepc_pkg;
  // ----------------------------------------------------------------
  // register addresses on the special-function-register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] FEPC_ADDR_MODE = 8'hea;
  localparam logic [7:0] FEPC_ADDR_CMD = 8'heb;
  localparam logic [7:0] FEPC_ADDR_STATUS = 8'hec;
  localparam logic [7:0] FEPC_ADDR_TIME = 8'hed;
  localparam logic [7:0] FEPC_ADDR_LOW = 8'hf2;
  localparam logic [7:0] FEPC_ADDR_MID = 8'hf3;
  localparam logic [7:0] FEPC_ADDR_HIGH = 8'hf4;
  localparam logic [7:0] FEPC_ADDR_DATA = 8'hf5;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FEPC_RST_MODE = 8'h00;
  localparam logic [7:0] FEPC_RST_CMD = 8'h03;
  localparam logic [7:0] FEPC_RST_STATUS = 8'h80;
  localparam logic [7:0] FEPC_RST_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int FEPC_MODE_FLASH = 7;
  localparam int FEPC_MODE_EEPROM = 6;
  localparam int FEPC_MODE_PGM = 5;
  localparam int FEPC_MODE_ERASE = 4;
  localparam int FEPC_MODE_PBUF = 3;
  localparam int FEPC_MODE_OTP = 2;
  localparam int FEPC_MODE_VFY = 1;
  localparam int FEPC_MODE_ENABLE = 0;
  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int FEPC_CMD_BULK_FLASH = 7;
  localparam int FEPC_CMD_BULK_EEPROM = 6;
  localparam int FEPC_CMD_EXIT1 = 5;
  localparam int FEPC_CMD_EXIT0 = 4;
  localparam int FEPC_CMD_WRITE = 3;
  localparam int FEPC_CMD_READ = 2;
  localparam int FEPC_CMD_CTRL_RST_N = 1;
  localparam int FEPC_CMD_PBUF_RST_N = 0;
  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int FEPC_ST_DONE = 7;
  localparam int FEPC_ST_VPASS = 6;
  localparam int FEPC_ST_IRQ = 3;
  localparam int FEPC_ST_WRITE_MODE_FLAG = 2;
  localparam int FEPC_ST_ERASE_MODE_FLAG = 1;
  localparam int FEPC_ST_VERIFY_MODE_FLAG = 0;
  // ----------------------------------------------------------------
  // unlock keys and memory geometry
  // ----------------------------------------------------------------
  localparam logic [7:0] FEPC_EE_KEY1 = 8'ha5;
  localparam logic [7:0] FEPC_EE_KEY2 = 8'h5a;
  localparam logic [15:0] FEPC_FL_ADDR1 = 16'hf555;
  localparam logic [15:0] FEPC_FL_ADDR2 = 16'hfaaa;
  localparam logic [7:0] FEPC_FL_KEY1 = 8'haa;
  localparam logic [7:0] FEPC_FL_KEY2 = 8'h55;
  localparam logic [7:0] FEPC_FL_KEY3 = 8'ha5;
  localparam int FEPC_FLASH_PAGE_BITS = 7;
  localparam int FEPC_EE_PAGE_BITS = 4;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FEPC_CLK_DIV = 128;
  localparam int FEPC_TIMER_BITS = 10;
  localparam int FEPC_PAGE_SHIFT = 1;
  localparam int FEPC_BULK_SHIFT = 2;
  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FEPC_IDLE = 6'b000001,
    FEPC_PE = 6'b000010,
    FEPC_VRD = 6'b000100,
    FEPC_VCAP = 6'b001000,
    FEPC_BRD = 6'b010000,
    FEPC_BCAP = 6'b100000
  } fepc_state_t;
endpackage

// ---- rtl/fepc_timer.sv ----
// program/erase timer: prescaler and 10-bit tick counter
`timescale 1ns/10ps
module fepc_timer
  import fepc_pkg::*;
#(
  parameter int DIV = fepc_pkg::FEPC_CLK_DIV
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic bulk_in,
  input wire logic [7:0] limit_in,
  output logic done_out
);
  import fepc_pkg::*;
  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);
  logic [PW-1:0] pre_q;
  logic [FEPC_TIMER_BITS-1:0] cnt_q;
  logic [FEPC_TIMER_BITS-1:0] last_q;
  logic run_q;
  logic tick;
  logic [FEPC_TIMER_BITS:0] ticks;
  // ----------------------------------------------------------------
  // end count: (limit+1) scaled by 2 for page, 4 for bulk, minus one
  // ----------------------------------------------------------------
  // done is decoded, not registered, so the caller's level ends on the exact count
  always_comb
  begin
    ticks = (11'(limit_in) + 11'd1) << (bulk_in ? FEPC_BULK_SHIFT : FEPC_PAGE_SHIFT); // R13 R14
    tick = run_q && (pre_q == PRE_LAST); // R10
    done_out = tick && (cnt_q == last_q); // R12
  end
  // prescaler and counter both restart with the operation
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || abort_in)
    begin
      pre_q <= '0;
      cnt_q <= '0;
      run_q <= 1'b0;
      last_q <= '0;
    end
    else if (start_in)
    begin
      pre_q <= '0;
      cnt_q <= '0; // R11
      run_q <= 1'b1;
      last_q <= ticks[FEPC_TIMER_BITS-1:0] - 10'd1;
    end
    else
    begin
      if (run_q)
        pre_q <= pre_q + PW'(1);
      if (tick)
      begin
        if (cnt_q == last_q)
          run_q <= 1'b0; // R12
        else
          cnt_q <= cnt_q + 10'd1; // R10
      end
    end
  end
endmodule // fepc_timer

// ---- rtl/fepc_top.sv ----
// flash/eeprom program, erase, verify and byte access controller
// What this block does
// R1: done flag clears at start, sets at end
// R2: status flag shows auto-verify pass or fail
// R3: request bit set when an operation completes
// R4: status shows write, erase, verify mode
// R5: address registers write-only, reads give checksum
// R6: program/erase ignores in-page address bits
// R7: auto-verify increments address by one
// R8: no mode: read/write move data byte
// R9: a5 then 5a to data unlocks eeprom
// R10: 10-bit timer ticks at clock/128
// R11: timer cleared when operation starts
// R12: timer end count from time register
// R13: page operation lasts (t+1)*2*128 clocks
// R14: bulk erase lasts (t+1)*4*128 clocks
// R15: software loads c3h at 20 MHz
// R16: flash 128 Kbyte, 128-byte pages
// R17: eeprom 4 Kbyte, 16-byte pages
// R18: in-system programming runs over debugger link
// R19: host enables debug before reading flash
// R20: verify start bit clears after one clock
// R21: only exit bits 11 leave program mode
// R22: program/erase only with enable bit set
// R23: aa/55/a5 write sequence unlocks flash
`timescale 1ns/10ps
module fepc_top
  import fepc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic xwr_in,
  input wire logic [15:0] xaddr_in,
  input wire logic [7:0] xdata_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_verify_ok_in,
  output logic [23:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic mem_prog_out,
  output logic mem_erase_out,
  output logic mem_bulk_out,
  output logic mem_flash_sel_out,
  output logic mem_eeprom_sel_out,
  output logic mem_otp_sel_out,
  output logic mem_pbuf_sel_out,
  output logic mem_pbuf_reset_out
);
  import fepc_pkg::*;
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [7:0] cmd_q;
  logic [7:0] time_q;
  logic [7:0] data_q;
  logic [23:0] addr_q;
  logic [23:0] sum_q;
  logic done_q;
  logic vpass_q;
  logic irq_q;
  logic fl_unlock_q;
  logic ee_unlock_q;
  logic [1:0] fl_step_q;
  logic ee_key_q;
  fepc_state_t state_q;
  logic timer_done;
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic wr_to(input logic [7:0] a);
    wr_to = sfr_wr_in && (sfr_addr_in == a); // R18
  endfunction
  function automatic logic [23:0] page_mask(input logic ee);
    page_mask = ee ? ~24'(2**FEPC_EE_PAGE_BITS - 1) : ~24'(2**FEPC_FLASH_PAGE_BITS - 1);
  endfunction
  logic sel_ee;
  logic pgm_mode;
  logic ers_mode;
  logic vfy_mode;
  logic no_mode;
  logic unlocked;
  logic go_write;
  logic go_read;
  logic pe_start;
  logic v_start;
  logic abort;
  logic v_last;
  logic done_set;
  always_comb
  begin
    sel_ee = mode_q[FEPC_MODE_EEPROM] && !mode_q[FEPC_MODE_FLASH];
    pgm_mode = mode_q[FEPC_MODE_PGM] && !mode_q[FEPC_MODE_VFY];
    ers_mode = mode_q[FEPC_MODE_ERASE] && !mode_q[FEPC_MODE_VFY];
    vfy_mode = mode_q[FEPC_MODE_VFY] && (mode_q[FEPC_MODE_PGM] || mode_q[FEPC_MODE_ERASE]);
    no_mode = !mode_q[FEPC_MODE_PGM] && !mode_q[FEPC_MODE_ERASE] && !mode_q[FEPC_MODE_VFY];
    unlocked = sel_ee ? ee_unlock_q : fl_unlock_q;
    go_write = cmd_q[FEPC_CMD_WRITE] && (state_q == FEPC_IDLE);
    go_read = cmd_q[FEPC_CMD_READ] && (state_q == FEPC_IDLE);
    pe_start = go_write && (pgm_mode || ers_mode) && mode_q[FEPC_MODE_ENABLE] && unlocked; // R22
    v_start = go_read && vfy_mode;
    abort = !cmd_q[FEPC_CMD_CTRL_RST_N];
    // verify stops once the next address leaves the page
    v_last = (((addr_q + 24'd1) & ~page_mask(sel_ee)) == 24'd0); // R16 R17
    done_set = timer_done || ((state_q == FEPC_VCAP) && v_last);
  end
  // ----------------------------------------------------------------
  // timed program/erase
  // ----------------------------------------------------------------
  fepc_timer #(
    .DIV(FEPC_CLK_DIV)
  ) fepc_timer_inst (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .start_in(pe_start),
    .abort_in(abort),
    .bulk_in(cmd_q[FEPC_CMD_BULK_FLASH] || cmd_q[FEPC_CMD_BULK_EEPROM]), // R14
    .limit_in(time_q), // R12
    .done_out(timer_done)
  );
  // ----------------------------------------------------------------
  // mode, time and command registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mode_q <= FEPC_RST_MODE;
      time_q <= FEPC_RST_ZERO;
    end
    else
    begin
      if (wr_to(FEPC_ADDR_MODE))
        mode_q <= sfr_wdata_in;
      if (wr_to(FEPC_ADDR_TIME))
        time_q <= sfr_wdata_in; // R15
    end
  end
  // strobe bits fall back to idle one clock after they are written
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      cmd_q <= FEPC_RST_CMD;
    else if (wr_to(FEPC_ADDR_CMD))
      cmd_q <= sfr_wdata_in;
    else
    begin
      cmd_q[FEPC_CMD_EXIT1] <= 1'b0; // R21
      cmd_q[FEPC_CMD_EXIT0] <= 1'b0; // R21
      cmd_q[FEPC_CMD_WRITE] <= 1'b0;
      cmd_q[FEPC_CMD_READ] <= 1'b0; // R20
      cmd_q[FEPC_CMD_CTRL_RST_N] <= 1'b1;
      cmd_q[FEPC_CMD_PBUF_RST_N] <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // unlock sequences
  // ----------------------------------------------------------------
  // any stray write restarts the flash sequence, so partial keys expire
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      fl_step_q <= 2'd0;
      fl_unlock_q <= 1'b0;
    end
    else if (cmd_q[FEPC_CMD_EXIT1] && cmd_q[FEPC_CMD_EXIT0])
    begin
      fl_step_q <= 2'd0;
      fl_unlock_q <= 1'b0; // R21
    end
    else if (xwr_in)
    begin
      fl_step_q <= 2'd0;
      if (fl_step_q == 2'd0 && xaddr_in == FEPC_FL_ADDR1 && xdata_in == FEPC_FL_KEY1)
        fl_step_q <= 2'd1; // R23
      else if (fl_step_q == 2'd1 && xaddr_in == FEPC_FL_ADDR2 && xdata_in == FEPC_FL_KEY2)
        fl_step_q <= 2'd2; // R23
      else if (fl_step_q == 2'd2 && xaddr_in == FEPC_FL_ADDR1 && xdata_in == FEPC_FL_KEY3)
        fl_unlock_q <= 1'b1; // R23
    end
  end
  // eeprom key rides on data register writes
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      ee_key_q <= 1'b0;
      ee_unlock_q <= 1'b0;
    end
    else if (cmd_q[FEPC_CMD_EXIT1] && cmd_q[FEPC_CMD_EXIT0])
    begin
      ee_key_q <= 1'b0;
      ee_unlock_q <= 1'b0; // R21
    end
    else if (wr_to(FEPC_ADDR_DATA))
    begin
      ee_key_q <= (sfr_wdata_in == FEPC_EE_KEY1); // R9
      if (ee_key_q && sfr_wdata_in == FEPC_EE_KEY2)
        ee_unlock_q <= 1'b1; // R9
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || abort)
      state_q <= FEPC_IDLE;
    else
    begin
      case (state_q)
        FEPC_IDLE:
        begin
          if (pe_start)
            state_q <= FEPC_PE;
          else if (v_start)
            state_q <= FEPC_VRD;
          else if (go_read && no_mode)
            state_q <= FEPC_BRD; // R8
        end
        FEPC_PE:
          if (timer_done)
            state_q <= FEPC_IDLE;
        FEPC_VRD:
          state_q <= FEPC_VCAP;
        FEPC_VCAP:
          state_q <= v_last ? FEPC_IDLE : FEPC_VRD;
        FEPC_BRD:
          state_q <= FEPC_BCAP;
        FEPC_BCAP:
          state_q <= FEPC_IDLE;
        default:
          state_q <= FEPC_IDLE;
      endcase
    end
  end
  // address: software writes, verify walks it one byte at a time
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      addr_q <= 24'h000000;
    else if (wr_to(FEPC_ADDR_LOW))
      addr_q[7:0] <= sfr_wdata_in;
    else if (wr_to(FEPC_ADDR_MID))
      addr_q[15:8] <= sfr_wdata_in;
    else if (wr_to(FEPC_ADDR_HIGH))
      addr_q[23:16] <= sfr_wdata_in;
    else if (state_q == FEPC_VCAP)
      addr_q <= addr_q + 24'd1; // R7
  end
  // data register: software writes, byte read loads it
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      data_q <= FEPC_RST_ZERO;
    else if (wr_to(FEPC_ADDR_DATA))
      data_q <= sfr_wdata_in;
    else if (state_q == FEPC_BCAP)
      data_q <= mem_rdata_in; // R8
  end
  // checksum over verified bytes, cleared by page-buffer-reset strobe only while the page-buffer mode bit is set
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      sum_q <= 24'h000000;
    else if (!cmd_q[FEPC_CMD_PBUF_RST_N] && mode_q[FEPC_MODE_PBUF])
      sum_q <= 24'h000000;
    else if (state_q == FEPC_VCAP)
      sum_q <= sum_q + {16'h0000, mem_rdata_in}; // R5
  end
  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // completion set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      done_q <= 1'b1;
      vpass_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (pe_start || v_start)
        done_q <= 1'b0; // R1
      else if (done_set || abort)
        done_q <= 1'b1; // R1
      if (v_start)
        vpass_q <= 1'b1;
      else if (state_q == FEPC_VCAP && !mem_verify_ok_in)
        vpass_q <= 1'b0; // R2
      else if (wr_to(FEPC_ADDR_STATUS))
        vpass_q <= sfr_wdata_in[FEPC_ST_VPASS];
      if (done_set)
        irq_q <= 1'b1; // R3
      else if (sfr_rd_in && sfr_addr_in == FEPC_ADDR_STATUS)
        irq_q <= 1'b0; // R3
      else if (wr_to(FEPC_ADDR_STATUS) && !sfr_wdata_in[FEPC_ST_IRQ])
        irq_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // read data, registered on the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      sfr_rdata_out <= 8'h00;
    else if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        FEPC_ADDR_MODE: sfr_rdata_out <= mode_q;
        FEPC_ADDR_CMD: sfr_rdata_out <= cmd_q;
        FEPC_ADDR_STATUS:
          sfr_rdata_out <= {done_q, vpass_q, 2'b00, irq_q,
                            pgm_mode, ers_mode, vfy_mode}; // R4
        FEPC_ADDR_TIME: sfr_rdata_out <= time_q;
        FEPC_ADDR_LOW: sfr_rdata_out <= sum_q[7:0]; // R5
        FEPC_ADDR_MID: sfr_rdata_out <= sum_q[15:8]; // R5
        FEPC_ADDR_HIGH: sfr_rdata_out <= sum_q[23:16]; // R5
        FEPC_ADDR_DATA: sfr_rdata_out <= data_q;
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // memory array controls
  // ----------------------------------------------------------------
  // program/erase level lasts exactly as long as the timer runs
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || abort)
    begin
      mem_prog_out <= 1'b0;
      mem_erase_out <= 1'b0;
      mem_bulk_out <= 1'b0;
    end
    else if (pe_start)
    begin
      mem_prog_out <= pgm_mode;
      mem_erase_out <= ers_mode;
      mem_bulk_out <= ers_mode && (cmd_q[FEPC_CMD_BULK_FLASH] || cmd_q[FEPC_CMD_BULK_EEPROM]);
    end
    else if (timer_done)
    begin
      mem_prog_out <= 1'b0;
      mem_erase_out <= 1'b0;
      mem_bulk_out <= 1'b0;
    end
  end
  // address, strobes and selects
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mem_addr_out <= 24'h000000;
      mem_wdata_out <= 8'h00;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_flash_sel_out <= 1'b0;
      mem_eeprom_sel_out <= 1'b0;
      mem_otp_sel_out <= 1'b0;
      mem_pbuf_sel_out <= 1'b0;
      mem_pbuf_reset_out <= 1'b0;
    end
    else
    begin
      mem_addr_out <= (pgm_mode || ers_mode) ? (addr_q & page_mask(sel_ee)) : addr_q; // R6
      mem_wdata_out <= data_q;
      mem_rd_out <= (state_q == FEPC_VRD) || (state_q == FEPC_BRD);
      mem_wr_out <= go_write && no_mode; // R8
      mem_flash_sel_out <= mode_q[FEPC_MODE_FLASH];
      mem_eeprom_sel_out <= mode_q[FEPC_MODE_EEPROM];
      mem_otp_sel_out <= mode_q[FEPC_MODE_OTP];
      mem_pbuf_sel_out <= mode_q[FEPC_MODE_PBUF];
      mem_pbuf_reset_out <= !cmd_q[FEPC_CMD_PBUF_RST_N] && !mode_q[FEPC_MODE_PBUF];
    end
  end
endmodule // fepc_top

// ---- tb/fepc_top_sva.sv ----
// port assertions for the program controller
`timescale 1ns/10ps
module fepc_chk
  import fepc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [23:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic mem_prog_out,
  input wire logic mem_erase_out,
  input wire logic mem_bulk_out,
  input wire logic mem_flash_sel_out,
  input wire logic mem_eeprom_sel_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  logic busy;
  logic [15:0] run_q;
  assign busy = mem_prog_out | mem_erase_out;
  // length of the timed level; lower bound only, since a larger time register value lengthens it
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !busy)
      run_q <= 16'h0000;
    else
      run_q <= run_q + 16'h0001;
  end
  sequence status_rd;
    sfr_rd_in && sfr_addr_in == FEPC_ADDR_STATUS;
  endsequence
  sequence verify_pair;
    mem_rd_out ##2 mem_rd_out;
  endsequence
  busy_flag_a: assert property (status_rd ##0 busy |=> !sfr_rdata_out[7])
    else $error("done flag high during timed op");
  write_flag_a: assert property (status_rd ##0 mem_prog_out |=> sfr_rdata_out[2])
    else $error("write mode flag low while programming");
  spare_bits_a: assert property (status_rd |=> sfr_rdata_out[5:4] == 2'b00)
    else $error("unused status bits not zero");
  verify_step_a: assert property (verify_pair |-> mem_addr_out == $past(mem_addr_out, 2) + 24'h1)
    else $error("verify address did not step by one");
  wr_pulse_a: assert property (mem_wr_out |=> !mem_wr_out)
    else $error("byte write strobe longer than one cycle");
  no_access_a: assert property (busy |-> !mem_rd_out && !mem_wr_out)
    else $error("byte access during timed op");
  page_mask_a: assert property (busy && !mem_bulk_out |-> (mem_eeprom_sel_out && !mem_flash_sel_out)
    ? mem_addr_out[3:0] == 4'h0 : mem_addr_out[6:0] == 7'h00)
    else $error("in-page address bits not ignored");
  page_time_a: assert property ($fell(busy) |-> run_q >= 16'd254)
    else $error("timed op shorter than one period");
  bulk_time_a: assert property ($fell(mem_bulk_out) |-> run_q >= 16'd510)
    else $error("bulk erase shorter than two periods");
  bulk_erase_a: assert property (mem_bulk_out |-> mem_erase_out)
    else $error("bulk level without erase level");
endmodule // fepc_chk

// ---- tb/fepc_mem_model.sv ----
// memory array stand-in: answers a read strobe while it stands
`timescale 1ns/10ps
module fepc_mem_model
(
  input wire logic sys_clk_in,
  input wire logic rd_in,
  input wire logic [23:0] addr_in,
  input wire logic bad_in,
  output logic [7:0] rdata_out,
  output logic ok_out
);
  // cells hold a pattern of their address; the controller captures at the end of the
  // strobe cycle, and between reads the lines show the inverse so stale data never passes
  always_comb
  begin
    rdata_out = rd_in ? (addr_in[7:0] ^ 8'h3c) : ~(addr_in[7:0] ^ 8'h3c);
    ok_out = rd_in ? !bad_in : bad_in;
  end
endmodule // fepc_mem_model

// ---- tb/fepc_top_tb.sv ----
// self-checking bench for the program controller
`timescale 1ns/10ps
module fepc_top_tb;
  import fepc_pkg::*;
  logic sys_clk_in, reset_in, sfr_wr_in, sfr_rd_in, xwr_in, bad, mem_verify_ok_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, xdata_in, mem_rdata_in, mem_wdata_out, v;
  logic [15:0] xaddr_in;
  logic [23:0] mem_addr_out;
  logic mem_rd_out, mem_wr_out, mem_prog_out, mem_erase_out, mem_bulk_out, mem_flash_sel_out;
  logic mem_eeprom_sel_out, mem_otp_sel_out, mem_pbuf_sel_out, mem_pbuf_reset_out;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  fepc_top fepc_top_inst (.sys_clk_in, .reset_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
    .sfr_wdata_in, .sfr_rdata_out, .xwr_in, .xaddr_in, .xdata_in, .mem_rdata_in,
    .mem_verify_ok_in, .mem_addr_out, .mem_wdata_out, .mem_rd_out, .mem_wr_out, .mem_prog_out,
    .mem_erase_out, .mem_bulk_out, .mem_flash_sel_out, .mem_eeprom_sel_out, .mem_otp_sel_out,
    .mem_pbuf_sel_out, .mem_pbuf_reset_out);
  fepc_mem_model fepc_mem_model_inst (.sys_clk_in, .rd_in(mem_rd_out), .addr_in(mem_addr_out),
    .bad_in(bad), .rdata_out(mem_rdata_in), .ok_out(mem_verify_ok_in));
  // 10 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bus cycles: one idle cycle between strobes keeps each strobe a single-cycle pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #10;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(posedge sys_clk_in);
    #10;
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #10;
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(posedge sys_clk_in);
    #10;
    sfr_rd_in = 1'b0;
    d = sfr_rdata_out;
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #10;
    xaddr_in = a;
    xdata_in = d;
    xwr_in = 1'b1;
    @(posedge sys_clk_in);
    #10;
    xwr_in = 1'b0;
  endtask
  // counts cycles of the timed level; a zero expectation means the start must be refused
  task automatic timed(input int exp);
    n = 0;
    for (int i = 0; i < 1400; i++)
    begin
      @(posedge sys_clk_in);
      #10;
      if (mem_prog_out || mem_erase_out)
        n++;
      else if (n > 0)
        break;
    end
    check("op_length", 16'(n >= exp - 4 && n <= exp), 16'h1);
    if (n == 1400)
      wrap_up();
  endtask
  task automatic test_reset();
    logic [7:0] a [6] = '{FEPC_ADDR_STATUS, FEPC_ADDR_TIME, FEPC_ADDR_LOW, FEPC_ADDR_MID,
      FEPC_ADDR_DATA, 8'h10};
    logic [7:0] e [6] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      rd(a[i], v);
      check("reset_value", v, e[i]);
    end
    wr(FEPC_ADDR_TIME, 8'hc3);
    rd(FEPC_ADDR_TIME, v);
    check("time_limit", v, 8'hc3);
    $display("test reset finished");
  endtask
  task automatic test_byte();
    wr(FEPC_ADDR_LOW, 8'h23);
    wr(FEPC_ADDR_MID, 8'h01);
    rd(FEPC_ADDR_LOW, v);
    check("addr_readback", v, 8'h00);
    wr(FEPC_ADDR_CMD, 8'h07);
    repeat (4) @(posedge sys_clk_in);
    rd(FEPC_ADDR_DATA, v);
    check("byte_read", v, 8'h23 ^ 8'h3c);
    wr(FEPC_ADDR_DATA, 8'h77);
    wr(FEPC_ADDR_CMD, 8'h0b);
    n = 0;
    for (int i = 0; i < 4 && n == 0; i++)
    begin
      @(posedge sys_clk_in);
      #10;
      if (mem_wr_out === 1'b1)
      begin
        n = 1;
        check("write_data", mem_wdata_out, 8'h77);
        check("write_addr", mem_addr_out[15:0], 16'h0123);
      end
    end
    check("byte_write", 16'(n), 16'h1);
    $display("test byte finished");
  endtask
  task automatic test_ee_prog();
    wr(FEPC_ADDR_DATA, FEPC_EE_KEY1);
    wr(FEPC_ADDR_DATA, FEPC_EE_KEY2);
    wr(FEPC_ADDR_MODE, 8'h60);
    wr(FEPC_ADDR_CMD, 8'h0b);
    timed(0);
    wr(FEPC_ADDR_MODE, 8'h61);
    wr(FEPC_ADDR_LOW, 8'h1f);
    wr(FEPC_ADDR_TIME, 8'h01);
    wr(FEPC_ADDR_CMD, 8'h0b);
    rd(FEPC_ADDR_STATUS, v);
    check("status_busy", v, 8'h04);
    timed(510);
    rd(FEPC_ADDR_STATUS, v);
    check("status_done", v, 8'h8c);
    rd(FEPC_ADDR_STATUS, v);
    check("irq_cleared", v, 8'h84);
    $display("test eeprom program finished");
  endtask
  task automatic test_verify();
    wr(FEPC_ADDR_MODE, 8'h63);
    wr(FEPC_ADDR_MID, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      bad = p[0];
      wr(FEPC_ADDR_LOW, 8'h0e);
      wr(FEPC_ADDR_CMD, 8'h07);
      repeat (8) @(posedge sys_clk_in);
      rd(FEPC_ADDR_CMD, v);
      check("start_cleared", v, 8'h03);
      rd(FEPC_ADDR_STATUS, v);
      check("verify_status", v, p ? 8'h89 : 8'hc9);
      rd(FEPC_ADDR_LOW, v);
      check("checksum", v, p ? 8'hca : 8'h65);
    end
    bad = 1'b0;
    $display("test verify finished");
  endtask
  task automatic test_bulk();
    logic [7:0] ex [3] = '{8'h13, 8'h23, 8'h33};
    xw(FEPC_FL_ADDR1, FEPC_FL_KEY1);
    xw(FEPC_FL_ADDR2, FEPC_FL_KEY2);
    xw(FEPC_FL_ADDR1, FEPC_FL_KEY3);
    wr(FEPC_ADDR_MODE, 8'h91);
    wr(FEPC_ADDR_TIME, 8'h00);
    check("mem_selects", {mem_flash_sel_out, mem_eeprom_sel_out, mem_otp_sel_out,
      mem_pbuf_sel_out}, 16'h8);
    for (int k = 0; k < 3; k++)
    begin
      wr(FEPC_ADDR_CMD, ex[k]);
      wr(FEPC_ADDR_CMD, 8'h8b);
      timed(k < 2 ? 512 : 0);
      rd(FEPC_ADDR_STATUS, v);
      check("bulk_status", v, k < 2 ? 8'h8a : 8'h82);
    end
    $display("test bulk erase finished");
  endtask
  // reset for 10 cycles, then the scenarios in order
  initial
  begin
    reset_in = 1'b1;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    xwr_in = 1'b0;
    bad = 1'b0;
    sfr_addr_in = 8'h00;
    sfr_wdata_in = 8'h00;
    xaddr_in = 16'h0000;
    xdata_in = 8'h00;
    repeat (10) @(posedge sys_clk_in);
    #10;
    reset_in = 1'b0;
    test_reset();
    test_byte();
    test_ee_prog();
    test_verify();
    test_bulk();
    wrap_up();
  end
endmodule // fepc_top_tb
bind fepc_top fepc_chk fepc_chk_inst (.sys_clk_in, .reset_in, .sfr_addr_in, .sfr_rd_in,
  .sfr_rdata_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_prog_out, .mem_erase_out,
  .mem_bulk_out, .mem_flash_sel_out, .mem_eeprom_sel_out);
